//--- rtl/ecil_pkg.sv
package ecil_pkg;
  localparam int          ECIL_NUM_CH     = 8;
  localparam logic [11:0] ECIL_ENCLR_OFF  = 12'h010;
  localparam logic [11:0] ECIL_ENSET_OFF  = 12'h014;
  localparam logic [11:0] ECIL_FLAG_OFF   = 12'h018;
  localparam logic [11:0] ECIL_PATH_OFF   = 12'h01C;
  localparam int          ECIL_OVR_LSB    = 0;
  localparam int          ECIL_EVD_LSB    = 8;
  localparam logic [15:0] ECIL_EN_RESET   = 16'h0000;
  localparam logic [15:0] ECIL_FLAG_RESET = 16'h0000;
  localparam logic [7:0]  ECIL_PATH_RESET = 8'h00;
  localparam logic [1:0]  ECIL_RESP_OKAY  = 2'b00;
  localparam logic [1:0]  ECIL_RESP_SLVERR = 2'b10;
endpackage : ecil_pkg

//--- rtl/ecil_flag_bit.sv
`timescale 1ns/1ps
`default_nettype none
// One sticky flag: set wins over a same-cycle clear
module ecil_flag_bit (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic set_in,
  input  wire logic clr_in,
  output logic      flag_out
);
  logic flag_reg;
  logic flag_next;

  assign flag_next = set_in | (flag_reg & ~clr_in);
  assign flag_out  = flag_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) flag_reg <= 1'b0;
    else flag_reg <= flag_next;
  end

  set_wins_a: assert property (@(posedge aclk) disable iff (!aresetn)
    set_in |=> flag_reg) else $error("flag lost a set");
endmodule : ecil_flag_bit
`default_nettype wire

//--- rtl/ecil_irq_logic.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Enable-clear one disables overrun interrupt
// - Enable-set one enables event-detected interrupt
// - Enable-set one enables overrun interrupt
// - Both enable registers read current enables
// - Event propagation sets event flag next cycle
// - Overrun sets overrun flag next cycle
// - Asynchronous path channels never set flags
// - Flag write one clears event flag
// - Flag write one clears overrun flag
// - Enable-clear one disables event-detected interrupt
module ecil_irq_logic (
  input  wire logic                                aclk,
  input  wire logic                                aresetn,
  input  wire logic [11:0]                         s_axi_awaddr,
  input  wire logic                                s_axi_awvalid,
  output logic                                     s_axi_awready,
  input  wire logic [31:0]                         s_axi_wdata,
  input  wire logic [3:0]                          s_axi_wstrb,
  input  wire logic                                s_axi_wvalid,
  output logic                                     s_axi_wready,
  output logic [1:0]                               s_axi_bresp,
  output logic                                     s_axi_bvalid,
  input  wire logic                                s_axi_bready,
  input  wire logic [11:0]                         s_axi_araddr,
  input  wire logic                                s_axi_arvalid,
  output logic                                     s_axi_arready,
  output logic [31:0]                              s_axi_rdata,
  output logic [1:0]                               s_axi_rresp,
  output logic                                     s_axi_rvalid,
  input  wire logic                                s_axi_rready,
  input  wire logic [ecil_pkg::ECIL_NUM_CH-1:0]    event_propagated,
  input  wire logic [ecil_pkg::ECIL_NUM_CH-1:0]    overrun_occurred,
  output logic [ecil_pkg::ECIL_NUM_CH-1:0]         async_path,
  output logic                                     irq
);
  import ecil_pkg::*;
  localparam int N = ECIL_NUM_CH;

  logic [11:0] awaddr_reg;
  logic        aw_held_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        w_held_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;
  logic [15:0] enable_reg;
  logic [15:0] enable_next;
  logic [7:0]  path_reg;
  logic [15:0] flag_vec;

  // Write channel capture; address and data may arrive in either order
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take  = s_axi_wvalid & s_axi_wready;
  assign s_axi_awready = ~aw_held_reg & ~bvalid_reg;
  assign s_axi_wready  = ~w_held_reg & ~bvalid_reg;
  wire wr_fire = aw_held_reg & w_held_reg;

  wire        sel_enclr = wr_fire & (awaddr_reg[11:2] == ECIL_ENCLR_OFF[11:2]);
  wire        sel_enset = wr_fire & (awaddr_reg[11:2] == ECIL_ENSET_OFF[11:2]);
  wire        sel_flag  = wr_fire & (awaddr_reg[11:2] == ECIL_FLAG_OFF[11:2]);
  wire        sel_path  = wr_fire & (awaddr_reg[11:2] == ECIL_PATH_OFF[11:2]);
  wire        wr_hit    = sel_enclr | sel_enset | sel_flag | sel_path;
  // Byte lanes 0 and 1 carry overrun and event bits
  wire [15:0] wmask     = {{8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}} & wdata_reg[15:0];
  wire [15:0] en_set    = sel_enset ? wmask : 16'h0000;
  wire [15:0] en_clr    = sel_enclr ? wmask : 16'h0000;
  wire [15:0] flag_clr  = sel_flag ? wmask : 16'h0000;

  assign enable_next = (enable_reg | en_set) & ~en_clr;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      awaddr_reg  <= 12'h000;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
    end else begin
      if (aw_take) awaddr_reg <= s_axi_awaddr;
      if (w_take) begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      aw_held_reg <= wr_fire ? 1'b0 : (aw_held_reg | aw_take);
      w_held_reg  <= wr_fire ? 1'b0 : (w_held_reg | w_take);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= ECIL_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_hit ? ECIL_RESP_OKAY : ECIL_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_reg <= ECIL_EN_RESET;
      path_reg   <= ECIL_PATH_RESET;
    end else begin
      enable_reg <= enable_next;
      if (sel_path && wstrb_reg[0]) path_reg <= wdata_reg[7:0];
    end
  end

  // Per-channel flags; asynchronous channels are masked at the source
  for (genvar c = 0; c < N; c++) begin : g_ch
    ecil_flag_bit u_evd (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .set_in   (event_propagated[c] & ~path_reg[c]),
      .clr_in   (flag_clr[ECIL_EVD_LSB + c]),
      .flag_out (flag_vec[ECIL_EVD_LSB + c])
    );
    ecil_flag_bit u_ovr (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .set_in   (overrun_occurred[c] & ~path_reg[c]),
      .clr_in   (flag_clr[ECIL_OVR_LSB + c]),
      .flag_out (flag_vec[ECIL_OVR_LSB + c])
    );
  end

  assign irq        = |(flag_vec & enable_reg);
  assign async_path = path_reg;

  // Read channel: one outstanding read, data registered
  wire        ar_take = s_axi_arvalid & s_axi_arready;
  wire [9:0]  ar_word = s_axi_araddr[11:2];
  wire        rd_en   = (ar_word == ECIL_ENCLR_OFF[11:2]) | (ar_word == ECIL_ENSET_OFF[11:2]);
  wire        rd_flag = ar_word == ECIL_FLAG_OFF[11:2];
  wire        rd_path = ar_word == ECIL_PATH_OFF[11:2];
  wire [31:0] rd_mux  = rd_en   ? {16'h0000, enable_reg} :
                        rd_flag ? {16'h0000, flag_vec} :
                        rd_path ? {24'h000000, path_reg} : 32'h0000_0000;
  assign s_axi_arready = ~rvalid_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= ECIL_RESP_OKAY;
    end else if (ar_take) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_mux;
      rresp_reg  <= (rd_en | rd_flag | rd_path) ? ECIL_RESP_OKAY : ECIL_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp  = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata  = rdata_reg;
  assign s_axi_rresp  = rresp_reg;

  // Checks
  enclr_ovr_a: assert property (@(posedge aclk) disable iff (!aresetn)
    en_clr[0] |=> !enable_reg[0]) else $error("overrun enable not cleared");
  enset_evd_a: assert property (@(posedge aclk) disable iff (!aresetn)
    en_set[8] && !en_clr[8] |=> enable_reg[8]) else $error("event enable not set");
  enset_ovr_a: assert property (@(posedge aclk) disable iff (!aresetn)
    en_set[0] && !en_clr[0] |=> enable_reg[0]) else $error("overrun enable not set");
  enable_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_take && rd_en |=> rdata_reg[15:0] == $past(enable_reg)) else $error("enable readback");
  evd_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    event_propagated[0] && !path_reg[0] |=> flag_vec[8]) else $error("event flag not set");
  ovr_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    overrun_occurred[0] && !path_reg[0] |=> flag_vec[0]) else $error("overrun flag not set");
  async_mask_a: assert property (@(posedge aclk) disable iff (!aresetn)
    path_reg[1] && !flag_vec[9] && $stable(path_reg) |=> !flag_vec[9])
    else $error("async channel set flag");
  flag_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    flag_clr[8] && !event_propagated[0] |=> !flag_vec[8]) else $error("event flag kept");
  ovr_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    flag_clr[0] && !overrun_occurred[0] |=> !flag_vec[0]) else $error("overrun flag kept");
  enclr_evd_a: assert property (@(posedge aclk) disable iff (!aresetn)
    en_clr[8] |=> !enable_reg[8]) else $error("event enable not cleared");
  irq_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
    irq == ((flag_vec & enable_reg) != 16'h0000)) else $error("irq mismatch");
  bresp_after_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire |=> s_axi_bvalid) else $error("no write response");

  // Bus protocol: answers stand until taken, no new request while one is pending
  bvalid_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  rvalid_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  wr_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  rd_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> !s_axi_arready) else $error("read taken while data pending");
  slverr_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire && !wr_hit |=> s_axi_bresp == ECIL_RESP_SLVERR)
    else $error("unmapped write not refused");
  rd_slverr_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_take && !(rd_en | rd_flag | rd_path) |=> s_axi_rresp == ECIL_RESP_SLVERR)
    else $error("unmapped read not refused");
  // Enables only move on a completed write; a stray change would mask interrupts
  en_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !wr_fire |=> enable_reg == $past(enable_reg)) else $error("enable changed alone");
  path_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
    sel_path && wstrb_reg[0] |=> path_reg == $past(wdata_reg[7:0]))
    else $error("path register not written");

  // Every channel checked, not only channel zero
  for (genvar k = 0; k < N; k++) begin : g_chk
    ch_enclr_ovr_a: assert property (@(posedge aclk) disable iff (!aresetn)
      en_clr[ECIL_OVR_LSB + k] |=> !enable_reg[ECIL_OVR_LSB + k])
      else $error("channel overrun enable not cleared");
    ch_enset_evd_a: assert property (@(posedge aclk) disable iff (!aresetn)
      en_set[ECIL_EVD_LSB + k] |=> enable_reg[ECIL_EVD_LSB + k])
      else $error("channel event enable not set");
    ch_enset_ovr_a: assert property (@(posedge aclk) disable iff (!aresetn)
      en_set[ECIL_OVR_LSB + k] |=> enable_reg[ECIL_OVR_LSB + k])
      else $error("channel overrun enable not set");
    ch_evd_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
      event_propagated[k] && !path_reg[k] |=> flag_vec[ECIL_EVD_LSB + k])
      else $error("channel event flag not set");
    ch_ovr_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
      overrun_occurred[k] && !path_reg[k] |=> flag_vec[ECIL_OVR_LSB + k])
      else $error("channel overrun flag not set");
    ch_evd_mask_a: assert property (@(posedge aclk) disable iff (!aresetn)
      path_reg[k] && !flag_vec[ECIL_EVD_LSB + k] |=> !flag_vec[ECIL_EVD_LSB + k])
      else $error("async channel set event flag");
    ch_ovr_mask_a: assert property (@(posedge aclk) disable iff (!aresetn)
      path_reg[k] && !flag_vec[ECIL_OVR_LSB + k] |=> !flag_vec[ECIL_OVR_LSB + k])
      else $error("async channel set overrun flag");
    ch_evd_clr_a: assert property (@(posedge aclk) disable iff (!aresetn)
      flag_clr[ECIL_EVD_LSB + k] && !event_propagated[k] |=> !flag_vec[ECIL_EVD_LSB + k])
      else $error("channel event flag kept");
    ch_ovr_clr_a: assert property (@(posedge aclk) disable iff (!aresetn)
      flag_clr[ECIL_OVR_LSB + k] && !overrun_occurred[k] |=> !flag_vec[ECIL_OVR_LSB + k])
      else $error("channel overrun flag kept");
    ch_enclr_evd_a: assert property (@(posedge aclk) disable iff (!aresetn)
      en_clr[ECIL_EVD_LSB + k] |=> !enable_reg[ECIL_EVD_LSB + k])
      else $error("channel event enable not cleared");
    // Flags are sticky: only a clear may drop them
    ch_evd_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
      flag_vec[ECIL_EVD_LSB + k] && !flag_clr[ECIL_EVD_LSB + k] |=> flag_vec[ECIL_EVD_LSB + k])
      else $error("channel event flag lost");
    ch_ovr_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
      flag_vec[ECIL_OVR_LSB + k] && !flag_clr[ECIL_OVR_LSB + k] |=> flag_vec[ECIL_OVR_LSB + k])
      else $error("channel overrun flag lost");
  end

  wr_done_c: cover property (@(posedge aclk) disable iff (!aresetn) wr_fire && sel_enset);
  rd_done_c: cover property (@(posedge aclk) disable iff (!aresetn) ar_take && rd_flag);
  irq_rise_c: cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq));
  set_clr_c: cover property (@(posedge aclk) disable iff (!aresetn)
    flag_clr[8] && event_propagated[0]);
  async_drop_c: cover property (@(posedge aclk) disable iff (!aresetn)
    event_propagated[1] && path_reg[1]);
endmodule : ecil_irq_logic
`default_nettype wire

//--- verif/ecil_event_model.sv
`timescale 1ns/1ps
`default_nettype none
// Far-side channel source: mask bits driven in the cycle after each cycle that fire is high
module ecil_event_model
  import ecil_pkg::*;
(
  input  wire logic                                aclk,
  input  wire logic                                fire,
  input  wire logic [7:0]                          ev_mask,
  input  wire logic [7:0]                          ov_mask,
  output logic [ecil_pkg::ECIL_NUM_CH-1:0]         event_propagated,
  output logic [ecil_pkg::ECIL_NUM_CH-1:0]         overrun_occurred
);
  always_ff @(posedge aclk) begin
    event_propagated <= fire ? ev_mask : 8'h00;
    overrun_occurred <= fire ? ov_mask : 8'h00;
  end
endmodule : ecil_event_model
`default_nettype wire

//--- verif/test_event_channel_irq_logic.sv
`timescale 1ns/1ps
`default_nettype none
module test_event_channel_irq_logic;
  import ecil_pkg::*;
  logic        aclk, aresetn, awv, wv, bready, arv, rready, fire;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, v, m;
  logic [7:0]  ev_m, ov_m, p;
  logic [3:0]  ws, s;
  logic [15:0] en, fl;
  logic [33:0] q[$];
  int          n_mismatch, compares;
  wire logic        awrdy, wrdy, bvalid, arrdy, rvalid, irq;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [7:0]  evp, ovr, apath;

  ecil_irq_logic i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awv), .s_axi_awready(awrdy), .s_axi_wdata(wdata), .s_axi_wstrb(ws),
    .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
    .s_axi_arready(arrdy), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .event_propagated(evp), .overrun_occurred(ovr),
    .async_path(apath), .irq(irq));
  ecil_event_model i_far (.aclk(aclk), .fire(fire), .ev_mask(ev_m), .ov_mask(ov_m),
    .event_propagated(evp), .overrun_occurred(ovr));

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic test_done;
    if (n_mismatch == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done

  // Handshakes judged at the falling edge, so the rising edge never races the design
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ha, hw, hb;
    @(posedge aclk);
    awaddr <= a;
    wdata  <= d;
    awv    <= 1'b1;
    wv     <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(negedge aclk);
      ha = awv && awrdy;
      hw = wv && wrdy;
      hb = bvalid;
      chk({32'h0, hb ? bresp : r}, {32'h0, r});
      @(posedge aclk);
      if (ha) awv <= 1'b0;
      if (hw) wv <= 1'b0;
      if (hb) break;
    end
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [15:0] e, input logic [1:0] r);
    logic ha, hr;
    q.push_back({16'h0, e, r});
    @(posedge aclk);
    araddr <= a;
    arv    <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(negedge aclk);
      ha = arv && arrdy;
      hr = rvalid;
      @(posedge aclk);
      if (ha) arv <= 1'b0;
      if (hr) break;
    end
    rready <= 1'b0;
  endtask : rd

  always @(negedge aclk) begin
    if (rvalid && rready && q.size() > 0) chk({rdata, rresp}, q.pop_front());
  end

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  initial begin
    #500000;
    n_mismatch++;
    test_done;
  end

  initial begin
    {aresetn, awv, wv, bready, arv, rready, fire} = 7'h00;
    ws = 4'hF;
    {awaddr, araddr, wdata, ev_m, ov_m, en, fl} = 0;
    v = $urandom(47290);
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ECIL_ENCLR_OFF, ECIL_EN_RESET, ECIL_RESP_OKAY);
    rd(ECIL_FLAG_OFF, ECIL_FLAG_RESET, ECIL_RESP_OKAY);
    for (int i = 0; i < 6; i++) begin
      v = $urandom;
      m = $urandom;
      p = (i < 2) ? 8'h00 : 8'($urandom);
      s = 4'($urandom);
      ws <= s;
      wr(ECIL_ENSET_OFF, v, ECIL_RESP_OKAY);
      ws <= 4'hF;
      en = en | (v[15:0] & {{8{s[1]}}, {8{s[0]}}});
      rd(ECIL_ENSET_OFF, en, ECIL_RESP_OKAY);
      wr(ECIL_ENCLR_OFF, m, ECIL_RESP_OKAY);
      en = en & ~m[15:0];
      rd(ECIL_ENCLR_OFF, en, ECIL_RESP_OKAY);
      wr(ECIL_PATH_OFF, {24'h0, p}, ECIL_RESP_OKAY);
      @(posedge aclk);
      ev_m <= 8'($urandom);
      ov_m <= 8'($urandom);
      fire <= 1'b1;
      @(posedge aclk);
      fire <= 1'b0;
      repeat (3) @(posedge aclk);
      fl = fl | {ev_m & ~p, ov_m & ~p};
      rd(ECIL_FLAG_OFF, fl, ECIL_RESP_OKAY);
      @(negedge aclk);
      chk({33'h0, irq}, {33'h0, |(fl & en)});
      wr(ECIL_FLAG_OFF, m ^ v, ECIL_RESP_OKAY);
      fl = fl & ~(m[15:0] ^ v[15:0]);
      rd(ECIL_FLAG_OFF, fl, ECIL_RESP_OKAY);
      @(negedge aclk);
      chk({33'h0, irq}, {33'h0, |(fl & en)});
    end
    rd(12'h020, 16'h0000, ECIL_RESP_SLVERR);
    wr(12'h024, 32'hFFFFFFFF, ECIL_RESP_SLVERR);
    test_done;
  end
endmodule : test_event_channel_irq_logic
`default_nettype wire
